// [protect_map.sv]
// block-protect decode: does an array address fall inside the protected region
// assumes a 24-bit byte address into a 16 MB array
`timescale 1ns/1ns
`include "status_one_defs.svh"
module protect_map (
  input  wire logic [2:0]  level,
  input  wire logic        unit_sel,
  input  wire logic        origin_sel,
  input  wire logic [23:0] addr,
  output logic             hit
);
  wire [4:0]  base_shift = unit_sel ? `SECTOR_SHIFT : `FRACTION_SHIFT;
  wire [4:0]  span_shift = base_shift + {2'b00, level} - 5'd1;
  wire [23:0] span_mask  = ~((24'h1 << span_shift) - 24'h1);
  wire [23:0] masked     = addr & span_mask;
  wire        top_hit    = masked == span_mask;
  wire        bottom_hit = masked == 24'h0;

  // level zero guards nothing, the top level guards all
  assign hit = (level == `LEVEL_ALL) |
               ((level != 3'h0) & (origin_sel ? bottom_hit : top_hit));
endmodule

// [serial_front.sv]
// serial pin front end: synchronises clock, select and data, assembles bytes
// assumes the link clock is far slower than mclk (at least 4 mclk per half period)
`timescale 1ns/1ns
module serial_front (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            frame_end,
  output logic            so,
  output logic            so_oe
);
  logic [2:0] sclk_sy_r;
  logic [2:0] cs_sy_r;
  logic [1:0] si_sy_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_in_r;
  logic [7:0] shift_out_r;

  wire active   = ~cs_sy_r[1];
  wire sck_rise = sclk_sy_r[1] & ~sclk_sy_r[2];
  wire sck_fall = ~sclk_sy_r[1] & sclk_sy_r[2];
  wire cs_rise  = cs_sy_r[1] & ~cs_sy_r[2];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_sy_r <= 3'h0;
      cs_sy_r   <= 3'h7;
      si_sy_r   <= 2'h0;
    end else begin
      sclk_sy_r <= {sclk_sy_r[1:0], sclk};
      cs_sy_r   <= {cs_sy_r[1:0], cs_n};
      si_sy_r   <= {si_sy_r[0], si};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || !active) begin
      bit_cnt_r  <= 3'h0;
      shift_in_r <= 7'h00;
      rx_valid   <= 1'b0;
    end else begin
      rx_valid <= sck_rise && bit_cnt_r == 3'h7;
      if (sck_rise) begin
        bit_cnt_r  <= bit_cnt_r + 3'h1;
        shift_in_r <= {shift_in_r[5:0], si_sy_r[1]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_byte <= 8'h00;
    end else if (active && sck_rise && bit_cnt_r == 3'h7) begin
      rx_byte <= {shift_in_r, si_sy_r[1]};
    end
  end

  // output changes on the falling edge so the host samples a settled bit
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shift_out_r <= 8'h00;
      so          <= 1'b0;
    end else if (active && sck_fall) begin
      if (bit_cnt_r == 3'h0) begin
        so          <= tx_byte[7];
        shift_out_r <= {tx_byte[6:0], 1'b0};
      end else begin
        so          <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      so_oe     <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      so_oe     <= active;
      frame_end <= cs_rise;
    end
  end
endmodule

// [spi_host_model.sv]
// host controller model: mode-0 frames, msb first, 320 ns link clock
// assumes a 40 ns mclk; si is scrambled once the frame ends
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic mclk,
  input  wire logic so,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic open_frame();
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // four mclk per half period; read bit taken mid high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
      rx[i] = so;
      repeat (2) @(posedge mclk);
      sclk <= 1'b0;
    end
  endtask
  // released data line shows the inverse, never the last bit
  task automatic close_frame();
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (10) @(posedge mclk);
  endtask
endmodule

// [status_one_defs.svh]
// constants for the first status register pair: opcodes, fields, resets
// assumes a 25 MHz mclk and mode-0 serial framing on the pins
`ifndef STATUS_ONE_DEFS_SVH
`define STATUS_ONE_DEFS_SVH

// opcodes decoded by this block
`define OP_READ_STATUS_ONE   8'h05
`define OP_READ_STATUS_TWO   8'h07
`define OP_NV_WRITE_ENABLE   8'h06
`define OP_VOL_WRITE_ENABLE  8'h50
`define OP_WRITE_DISABLE     8'h04
`define OP_WRITE_REGISTERS   8'h01
`define OP_READ_ANY          8'h65
`define OP_WRITE_ANY         8'h71
`define OP_CLEAR_STATUS      8'h30
`define OP_SUSPEND           8'h75
`define OP_RESET_ARM         8'h66
`define OP_RESET_GO          8'h99
`define OP_PAGE_PROGRAM      8'h02
`define OP_SECTOR_ERASE      8'h20
`define OP_BLOCK_ERASE       8'hd8
`define OP_CHIP_ERASE        8'h60

// register addresses for the any-register commands
`define ADDR_STATUS_ONE_NV   24'h000000
`define ADDR_STATUS_ONE_LIVE 24'h800000
`define ADDR_STATUS_TWO_LIVE 24'h800001

// status one field positions
`define BIT_LOCK             7
`define BIT_UNIT             6
`define BIT_ORIGIN           5
`define LEVEL_HI             4
`define LEVEL_LO             2
`define BIT_LATCH            1
`define BIT_BUSY             0

// status two field positions
`define BIT_ERASE_FAIL       6
`define BIT_PROG_FAIL        5

// shipped contents of the non-volatile copy
`define STATUS_ONE_NV_RESET  8'h00

// protect geometry: log2 of sector, of 1/64 array, and address width
`define SECTOR_SHIFT         5'd12
`define FRACTION_SHIFT       5'd18
`define ADDR_BITS            24
`define LEVEL_ALL            3'h7
`define ADDR_BYTES           2'd3

`endif

// [status_one_pkg.sv]
// types shared by the status register pair and its helpers
// assumes status_one_defs.svh holds every number
package status_one_pkg;

  typedef enum {
    st_opcode,
    st_addr,
    st_write_data,
    st_read,
    st_ignore
  } cmd_state_e;

  typedef enum logic [1:0] {
    op_program,
    op_sector_erase,
    op_block_erase,
    op_chip_erase
  } array_op_e;

endpackage

// [status_register_one_protect.sv]
// first status register pair: non-volatile defaults and live copy, command decode
// assumes a same-clock program/erase engine and same-clock quad mode flags
//
// Functional notes
// - lock, unit and origin live bits start from their defaults, shipped zero.
// - default level bits 4..2 load the live protect level after reset, shipped zero.
// - default bits 1..0 seed latch and busy; read-only and always zero.
// - lock set with protect pin low and neither quad mode set refuses every lockable register write.
// - quad peripheral or quad io mode forces internal protect level high.
// - pin high or lock clear allows lockable writes; other registers never gated.
// - unit select zero counts in 256kB (1/64 array) fractions, one in 4kB sectors.
// - origin zero protects from top addresses, one from address zero.
// - three level bits pick a protected fraction refusing program and erase.
// - live lock and origin follow writes to their non-volatile copies.
// - no program, erase or register write starts unless the latch is set.
// - write disable clears the latch.
// - successful completion clears latch; failure leaves it for clear status.
// - power-up and both resets load latch from its default bit.
// - register writes never alter latch or busy bits directly.
// - while busy only status reads, read-any, suspend, clear and reset pass.
// - suspend accepted only while an array operation really runs.
// - an error flag keeps busy high until clear status or soft reset.
// - opcodes 05h read, 50h volatile enable, 30h clear status.
// - opcodes 06h, 04h, 01h, 65h and 71h for the non-volatile copy.
// - erase and program failure flags set on failure, clear only on clear status or soft reset.
`timescale 1ns/1ns
`include "status_one_defs.svh"
module status_register_one_protect (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   si,
  input  wire logic                   protect_n,
  input  wire logic                   quad_peripheral_mode,
  input  wire logic                   quad_io_mode,
  input  wire logic                   engine_done,
  input  wire logic                   engine_fail,
  input  wire logic                   engine_paused,
  output logic                        so,
  output logic                        so_oe,
  output logic                        engine_go,
  output status_one_pkg::array_op_e   engine_kind,
  output logic [23:0]                 engine_addr,
  output logic                        engine_suspend,
  output logic                        lockable_write_ok
);
  import status_one_pkg::*;

  cmd_state_e  state_r;
  logic [7:0]  opcode_r;
  logic [23:0] addr_r;
  logic [1:0]  addr_cnt_r;
  logic [7:0]  tx_byte_r;
  logic [7:0]  nv_r;
  logic        lock_r;
  logic        unit_r;
  logic        origin_r;
  logic [2:0]  level_r;
  logic        latch_r;
  logic        busy_r;
  logic        running_r;
  logic        erase_fail_r;
  logic        prog_fail_r;
  logic        vol_mode_r;
  logic        arm_r;
  logic        pending_r;
  logic [1:0]  pin_sy_r;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        frame_end;
  logic        front_so;
  logic        front_so_oe;
  logic        target_hit;

  serial_front u_front (
    .mclk      (mclk),
    .nrst      (nrst),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .si        (si),
    .tx_byte   (tx_byte_r),
    .rx_valid  (rx_valid),
    .rx_byte   (rx_byte),
    .frame_end (frame_end),
    .so        (front_so),
    .so_oe     (front_so_oe)
  );

  protect_map u_map (
    .level      (level_r),
    .unit_sel   (unit_r),
    .origin_sel (origin_r),
    .addr       (addr_r),
    .hit        (target_hit)
  );

  // live image and second status image as seen by the reads
  wire [7:0] live_image = {lock_r, unit_r, origin_r, level_r, latch_r, busy_r};
  wire [7:0] two_image  = {1'b0, erase_fail_r, prog_fail_r, 5'h00};

  // pin is external, so it is synchronised before anything reads it
  wire pin_level   = pin_sy_r[1] | quad_peripheral_mode | quad_io_mode;
  wire locked      = lock_r & ~pin_level;
  wire reg_write   = latch_r & ~locked;

  wire op_byte     = rx_valid && state_r == st_opcode;
  wire busy_pass   = rx_byte == `OP_READ_STATUS_ONE || rx_byte == `OP_READ_STATUS_TWO ||
                     rx_byte == `OP_READ_ANY || rx_byte == `OP_SUSPEND ||
                     rx_byte == `OP_CLEAR_STATUS || rx_byte == `OP_RESET_ARM ||
                     rx_byte == `OP_RESET_GO;
  wire accept      = op_byte & (~busy_r | busy_pass);
  wire is_array    = rx_byte == `OP_PAGE_PROGRAM || rx_byte == `OP_SECTOR_ERASE ||
                     rx_byte == `OP_BLOCK_ERASE || rx_byte == `OP_CHIP_ERASE;
  wire needs_addr  = is_array & (rx_byte != `OP_CHIP_ERASE) ||
                     rx_byte == `OP_READ_ANY || rx_byte == `OP_WRITE_ANY;

  wire do_soft_rst = accept & rx_byte == `OP_RESET_GO & arm_r;
  wire do_clear    = accept & rx_byte == `OP_CLEAR_STATUS;
  wire do_nv_en    = accept & rx_byte == `OP_NV_WRITE_ENABLE;
  wire do_vol_en   = accept & rx_byte == `OP_VOL_WRITE_ENABLE;
  wire do_disable  = accept & rx_byte == `OP_WRITE_DISABLE;
  wire do_suspend  = accept & rx_byte == `OP_SUSPEND & running_r;

  // register write data byte and where it lands
  wire data_byte   = rx_valid && state_r == st_write_data;
  wire any_nv      = opcode_r == `OP_WRITE_ANY && addr_r == `ADDR_STATUS_ONE_NV;
  wire any_live    = opcode_r == `OP_WRITE_ANY && addr_r == `ADDR_STATUS_ONE_LIVE;
  wire wrr_nv      = opcode_r == `OP_WRITE_REGISTERS & ~vol_mode_r;
  wire wrr_live    = opcode_r == `OP_WRITE_REGISTERS & vol_mode_r;
  wire write_nv    = data_byte & reg_write & (wrr_nv | any_nv);
  wire write_live  = data_byte & reg_write & (wrr_live | any_live);
  wire write_done  = write_nv | write_live;

  // array launch happens once the frame closes with a full address or after a chip erase opcode
  wire launch_req  = frame_end & pending_r;
  wire launch_ok   = launch_req & latch_r & ~target_hit & ~busy_r;
  wire launch_bad  = launch_req & latch_r & target_hit & ~busy_r;
  wire is_erase    = opcode_r != `OP_PAGE_PROGRAM;
  wire run_erase   = engine_kind != op_program;  // later frames overwrite opcode_r

  wire [7:0] any_read = addr_r == `ADDR_STATUS_ONE_NV   ? nv_r :
                        addr_r == `ADDR_STATUS_ONE_LIVE ? live_image :
                        addr_r == `ADDR_STATUS_TWO_LIVE ? two_image : 8'h00;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_sy_r <= 2'h0;
    end else begin
      pin_sy_r <= {pin_sy_r[0], protect_n};
    end
  end

  // command sequencing per frame
  always_ff @(posedge mclk) begin
    if (!nrst || frame_end) begin
      state_r    <= st_opcode;
      addr_cnt_r <= 2'h0;
    end else if (op_byte) begin
      if (!accept) begin
        state_r <= st_ignore;
      end else if (needs_addr) begin
        state_r <= st_addr;
      end else if (rx_byte == `OP_WRITE_REGISTERS) begin
        state_r <= st_write_data;
      end else if (rx_byte == `OP_READ_STATUS_ONE || rx_byte == `OP_READ_STATUS_TWO) begin
        state_r <= st_read;
      end else begin
        state_r <= st_ignore;
      end
    end else if (rx_valid) begin
      case (state_r)
        st_addr: begin
          addr_cnt_r <= addr_cnt_r + 2'h1;
          if (addr_cnt_r == `ADDR_BYTES - 2'h1) begin
            if (opcode_r == `OP_READ_ANY) begin
              state_r <= st_read;
            end else if (opcode_r == `OP_WRITE_ANY) begin
              state_r <= st_write_data;
            end else begin
              state_r <= st_ignore;
            end
          end
        end
        st_write_data: state_r <= st_ignore;
        st_read:       state_r <= st_read;
        st_ignore:     state_r <= st_ignore;
        default:       state_r <= st_ignore;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      opcode_r <= 8'h00;
      addr_r   <= 24'h0;
    end else if (op_byte) begin
      opcode_r <= rx_byte;
      addr_r   <= 24'h0;
    end else if (rx_valid && state_r == st_addr) begin
      addr_r <= {addr_r[15:0], rx_byte};
    end
  end

  // read data refreshes each byte so busy and flags stay current
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tx_byte_r <= 8'h00;
    end else if (state_r == st_read) begin
      case (opcode_r)
        `OP_READ_STATUS_ONE: tx_byte_r <= live_image;
        `OP_READ_STATUS_TWO: tx_byte_r <= two_image;
        `OP_READ_ANY:        tx_byte_r <= any_read;
        default:             tx_byte_r <= 8'h00;
      endcase
    end else begin
      tx_byte_r <= 8'h00;
    end
  end

  // non-volatile copy; low two bits are factory-fixed and never written
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      nv_r <= `STATUS_ONE_NV_RESET;
    end else if (write_nv) begin
      nv_r <= {rx_byte[7:2], nv_r[1:0]};
    end
  end

  // live protection fields
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lock_r   <= 1'b0;
      unit_r   <= 1'b0;
      origin_r <= 1'b0;
      level_r  <= 3'h0;
    end else if (do_soft_rst) begin
      lock_r   <= nv_r[`BIT_LOCK];
      unit_r   <= nv_r[`BIT_UNIT];
      origin_r <= nv_r[`BIT_ORIGIN];
      level_r  <= nv_r[`LEVEL_HI:`LEVEL_LO];
    end else if (write_live) begin
      lock_r   <= rx_byte[`BIT_LOCK];
      unit_r   <= rx_byte[`BIT_UNIT];
      origin_r <= rx_byte[`BIT_ORIGIN];
      level_r  <= rx_byte[`LEVEL_HI:`LEVEL_LO];
    end else if (write_nv) begin
      lock_r   <= rx_byte[`BIT_LOCK];
      origin_r <= rx_byte[`BIT_ORIGIN];
    end
  end

  // latch: written bytes never reach it, only commands and completion
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      latch_r    <= 1'b0;
      vol_mode_r <= 1'b0;
    end else if (do_soft_rst) begin
      latch_r    <= nv_r[`BIT_LATCH];
      vol_mode_r <= 1'b0;
    end else if (do_nv_en || do_vol_en) begin
      latch_r    <= 1'b1;
      vol_mode_r <= do_vol_en;
    end else if (do_disable || do_clear) begin
      latch_r    <= 1'b0;
      vol_mode_r <= 1'b0;
    end else if (write_done || engine_done) begin
      latch_r    <= 1'b0;
      vol_mode_r <= 1'b0;
    end
  end

  // failure flags: a failure in the clearing cycle still sets
  always_ff @(posedge mclk) begin
    if (!nrst || do_soft_rst) begin
      erase_fail_r <= 1'b0;
      prog_fail_r  <= 1'b0;
    end else begin
      erase_fail_r <= (erase_fail_r & ~do_clear) |
                      (engine_fail & running_r & run_erase) | (launch_bad & is_erase);
      prog_fail_r  <= (prog_fail_r & ~do_clear) |
                      (engine_fail & running_r & ~run_erase) | (launch_bad & ~is_erase);
    end
  end

  // busy follows the engine and sticks while a failure is pending
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_r    <= 1'b0;
      running_r <= 1'b0;
    end else if (do_soft_rst) begin
      busy_r    <= nv_r[`BIT_BUSY];
      running_r <= 1'b0;
    end else if (launch_ok) begin
      busy_r    <= 1'b1;
      running_r <= 1'b1;
    end else if (launch_bad || (engine_fail && running_r)) begin
      busy_r    <= 1'b1;
      running_r <= 1'b0;
    end else if (running_r && (engine_done || engine_paused)) begin
      busy_r    <= 1'b0;
      running_r <= 1'b0;
    end else if (do_clear && (erase_fail_r || prog_fail_r)) begin
      busy_r    <= 1'b0;
    end
  end

  // two-step reset: arming byte, any other opcode disarms
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arm_r <= 1'b0;
    end else if (op_byte) begin
      arm_r <= accept && rx_byte == `OP_RESET_ARM;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || frame_end || do_soft_rst) begin
      pending_r <= 1'b0;
    end else if (accept && rx_byte == `OP_CHIP_ERASE) begin
      pending_r <= 1'b1;
    end else if (rx_valid && state_r == st_addr && addr_cnt_r == `ADDR_BYTES - 2'h1) begin
      pending_r <= opcode_r != `OP_READ_ANY && opcode_r != `OP_WRITE_ANY;
    end
  end

  // engine handshake; chip erase is checked at address zero: refused at level 7 or, with origin one, any nonzero level
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      engine_go      <= 1'b0;
      engine_kind    <= op_program;
      engine_addr    <= 24'h0;
      engine_suspend <= 1'b0;
    end else begin
      engine_go      <= launch_ok;
      engine_suspend <= do_suspend;
      if (launch_req) begin
        engine_addr <= addr_r;
        case (opcode_r)
          `OP_PAGE_PROGRAM: engine_kind <= op_program;
          `OP_SECTOR_ERASE: engine_kind <= op_sector_erase;
          `OP_BLOCK_ERASE:  engine_kind <= op_block_erase;
          default:          engine_kind <= op_chip_erase;
        endcase
      end
    end
  end

  // other register banks share the same lock verdict
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lockable_write_ok <= 1'b0;
      so                <= 1'b0;
      so_oe             <= 1'b0;
    end else begin
      lockable_write_ok <= reg_write & ~busy_r;
      so                <= front_so;
      so_oe             <= front_so_oe;
    end
  end
endmodule

// [status_register_one_protect_chk.sv]
// checker for the status pair: pulse shapes, frame timing, busy gating
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ns
module status_register_one_protect_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic engine_done,
  input wire logic engine_fail,
  input wire logic engine_paused,
  input wire logic so_oe,
  input wire logic engine_go,
  input wire logic engine_suspend,
  input wire logic lockable_write_ok
);
  logic run_r;
  logic run_nxt;
  logic stop;
  // soft reset is invisible here, so this only approximates busy
  assign stop = engine_done | engine_fail | engine_paused;
  assign run_nxt = engine_go ? 1'b1 : (stop ? 1'b0 : run_r);
  always_ff @(posedge mclk) begin
    run_r <= nrst ? run_nxt : 1'b0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_go_one_cycle: assert property (engine_go |=> !engine_go)
    else $error("start pulse too long");
  a_go_after_frame: assert property (engine_go |-> cs_n && $past(cs_n))
    else $error("start inside a frame");
  a_go_when_idle: assert property (engine_go |-> !run_r)
    else $error("start while busy");
  a_susp_one_cycle: assert property (engine_suspend |=> !engine_suspend)
    else $error("suspend pulse too long");
  a_susp_needs_run: assert property (engine_suspend |-> run_r)
    else $error("suspend with no operation");
  a_go_blocks_ok: assert property (engine_go |-> ##[1:3] !lockable_write_ok)
    else $error("writes open after start");
  a_run_blocks_ok: assert property (run_r && $past(run_r, 3) |-> !lockable_write_ok)
    else $error("writes open while running");
  a_oe_on_frame: assert property ($fell(cs_n) |-> ##[2:5] so_oe)
    else $error("output not enabled in frame");
  a_oe_off_idle: assert property ($rose(cs_n) |-> ##[2:5] !so_oe)
    else $error("output left enabled");
  c_go: cover property (engine_go);
  c_suspend: cover property (engine_suspend);
  c_ok: cover property ($rose(lockable_write_ok));
endmodule

// [status_register_one_protect_tb.sv]
// testbench for the status pair: host frames plus engine event pulses
// assumes the design files and host model are compiled first
`timescale 1ns/1ns
module status_register_one_protect_tb;
  import status_one_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        protect_n = 1'b1;
  logic        quad_io_mode = 1'b0;
  logic        quad_peripheral_mode = 1'b0;
  logic [2:0]  ev = 3'b000;
  logic        sclk, cs_n, si, so, so_oe, engine_go, engine_suspend, ok;
  logic [23:0] engine_addr;
  logic [23:0] addr_seen;
  logic [7:0]  rx;
  array_op_e   engine_kind;
  array_op_e   kind_seen;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          go_cnt = 0;
  int          sus_cnt = 0;
  always #20 mclk = ~mclk;
  spi_host_model host_u (.mclk(mclk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
  status_register_one_protect dut_u (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si), .protect_n(protect_n),
    .quad_peripheral_mode(quad_peripheral_mode), .quad_io_mode(quad_io_mode),
    .engine_done(ev[0]), .engine_fail(ev[1]), .engine_paused(ev[2]), .so(so), .so_oe(so_oe),
    .engine_go(engine_go), .engine_kind(engine_kind), .engine_addr(engine_addr),
    .engine_suspend(engine_suspend), .lockable_write_ok(ok));
  always @(posedge mclk) begin
    if (engine_go) begin
      go_cnt++;
      kind_seen = engine_kind;
      addr_seen = engine_addr;
    end
    if (engine_suspend)
      sus_cnt++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic ha, input logic [23:0] a,
                       input logic hd, input logic [7:0] d, output logic [7:0] q);
    host_u.open_frame();
    host_u.xfer(op, q);
    for (int i = 2; i >= 0; i--)
      if (ha)
        host_u.xfer(a[8*i+:8], q);
    if (hd)
      host_u.xfer(d, q);
    host_u.close_frame();
  endtask
  task automatic cmd(input logic [7:0] op);
    frame(op, 1'b0, 24'h0, 1'b0, 8'h00, rx);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    frame(op, 1'b0, 24'h0, 1'b1, d, rx);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    frame(op, op == 8'h65, 24'h0, 1'b1, 8'hff, rx);
    check(rx, exp);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 3'b000;
  endtask
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // far above the roughly 7.8k cycles the sequence needs
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h05, 8'h00);
    rd(8'h65, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h65, 8'h00);
    cmd(8'h06);
    rd(8'h05, 8'h02);
    wr(8'h01, 8'hff);
    rd(8'h65, 8'hfc);
    rd(8'h05, 8'ha0);
    protect_n <= 1'b0;
    cmd(8'h06);
    wr(8'h01, 8'h00);
    rd(8'h65, 8'hfc);
    check(ok, 1'b0);
    quad_peripheral_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    check(ok, 1'b1);
    quad_peripheral_mode <= 1'b0;
    quad_io_mode <= 1'b1;
    cmd(8'h06);
    check(ok, 1'b1);
    wr(8'h01, 8'h00);
    rd(8'h65, 8'h00);
    quad_io_mode <= 1'b0;
    cmd(8'h50);
    wr(8'h01, 8'h1c);
    rd(8'h05, 8'h1c);
    cmd(8'h06);
    frame(8'h02, 1'b1, 24'h000100, 1'b0, 8'h00, rx);
    rd(8'h07, 8'h20);
    cmd(8'h04);
    rd(8'h05, 8'h1f);
    cmd(8'h30);
    rd(8'h05, 8'h1c);
    rd(8'h07, 8'h00);
    cmd(8'h50);
    wr(8'h01, 8'h00);
    cmd(8'h06);
    cmd(8'h04);
    rd(8'h05, 8'h00);
    cmd(8'h06);
    frame(8'hd8, 1'b1, 24'h123456, 1'b0, 8'h00, rx);
    check(go_cnt, 1);
    check(kind_seen, op_block_erase);
    check(addr_seen, 24'h123456);
    rd(8'h05, 8'h03);
    cmd(8'h75);
    check(sus_cnt, 1);
    pulse(3'b100);
    rd(8'h05, 8'h02);
    cmd(8'h75);
    check(sus_cnt, 1);
    frame(8'h02, 1'b1, 24'h000010, 1'b0, 8'h00, rx);
    check(go_cnt, 2);
    pulse(3'b001);
    rd(8'h05, 8'h00);
    cmd(8'h06);
    frame(8'h02, 1'b1, 24'h000020, 1'b0, 8'h00, rx);
    check(go_cnt, 3);
    rd(8'h05, 8'h03);
    pulse(3'b010);
    rd(8'h07, 8'h20);
    rd(8'h05, 8'h03);
    cmd(8'h30);
    rd(8'h05, 8'h00);
    cmd(8'h50);
    wr(8'h01, 8'h1c);
    cmd(8'h66);
    cmd(8'h99);
    rd(8'h05, 8'h00);
    finish_test();
  end
endmodule
bind status_register_one_protect status_register_one_protect_chk chk_u (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .engine_done(engine_done),
  .engine_fail(engine_fail), .engine_paused(engine_paused), .so_oe(so_oe),
  .engine_go(engine_go), .engine_suspend(engine_suspend),
  .lockable_write_ok(lockable_write_ok));
